//--- logic/ecr_edge_counter.sv
// Functional notes
// R01: each counter loads a starting count and holds it until counting begins.
// R02: count changes only on the chosen rising or falling edge of the source.
// R03: direction is up, down or taken from an external channel.
// R04: external direction: high counts up, low counts down; channel selectable.
// R05: enabled reload edge overwrites count with the reload value.
// R06: enabled pause holds the count while pause channel is at its level.
// R07: armed counter waits for a first edge, then counts later edges.
// R08: passthrough mode exposes each channel level directly for reading.
// R09: passthrough mode produces no counter results on any channel.
// R10: passthrough applies only polarity; the glitch filter is bypassed.
// R11: source, reload, direction and pause inputs route from any channel.
// R12: counter n source defaults to channel n.
// R13: reload defaults are channels 3, 4, 5, 0, 1, 2.
// R14: direction defaults 5,2,4,1,3,0; pause defaults 4,5,1,2,0,3.
// R15: reading a count returns its present value without disturbing it.
// R16: reload and counted edge in one cycle: reload wins.
// R17: inputs are synchronised and each edge is a one-cycle event.
//
// Chosen here: the placing of the registers and the APB slave port.
module ecr_edge_counter #(
  parameter int CW       = ecr_pkg::ECR_CW,
  parameter int FILT_CYC = ecr_pkg::ECR_FILT_CYC
) (
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  input  wire logic [ecr_pkg::ECR_NCH-1:0] i_chan,
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [ecr_pkg::ECR_AW-1:0]  i_paddr,
  input  wire logic [31:0]                i_pwdata,
  input  wire logic [3:0]                 i_pstrb,
  output logic      [31:0]                o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  output logic      [ecr_pkg::ECR_NCH-1:0] o_di
);
  import ecr_pkg::*;
  // every check runs on the one module clock and sleeps through reset
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  typedef struct packed {
    logic [31:0]                ctrl;
    logic [ECR_NCH-1:0][31:0]   cfg;
    logic [ECR_NCH-1:0][CW-1:0] init;
    logic [ECR_NCH-1:0][CW-1:0] rld;
    logic [ECR_NCH-1:0][CW-1:0] cnt;
    ecr_ph_t [ECR_NCH-1:0]      ph;
    logic [ECR_NCH-1:0]         prev;
    logic [ECR_NCH-1:0]         di;
    logic [31:0]                rdata;
    logic                       rdy;
    logic                       err;
  } ecr_st_t;
  ecr_st_t s_q, s_d;

  logic [ECR_NCH-1:0] lvl_w;
  logic [ECR_NCH-1:0] pass_w;
  logic [ECR_NCH-1:0] rise_w;
  logic [ECR_NCH-1:0] fall_w;
  logic [ECR_NCH-1:0] act_w;
  logic [ECR_NCH-1:0] rtrg_w;
  logic [ECR_NCH-1:0] pause_w;
  logic [ECR_NCH-1:0] up_w;
  logic [ECR_NCH-1:0] arm_w;
  logic [ECR_NCH-1:0] wrc_w;
  logic               pass_mode;
  logic               wr_acc;
  logic [3:0]         a_blk;
  logic [1:0]         a_wrd;

  for (genvar c = 0; c < ECR_NCH; c++) begin : g_ch
    ecr_chan_cond #(
      .FILT_CYC (FILT_CYC)
    ) u_cond (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_raw     (i_chan[c]),
      .i_filt_en (s_q.ctrl[ECR_F_FEN + c]),
      .i_inv     (s_q.ctrl[ECR_F_INV + c]),
      .o_lvl     (lvl_w[c]),
      .o_pass    (pass_w[c])
    );
  end

  assign pass_mode = s_q.ctrl[ECR_F_PASS];
  assign rise_w    = lvl_w & ~s_q.prev;      // [R17]
  assign fall_w    = ~lvl_w & s_q.prev;      // [R17]
  assign a_blk     = i_paddr[7:4];
  assign a_wrd     = i_paddr[3:2];
  // the write lands on the edge that closes the access phase
  assign wr_acc    = i_psel && i_penable && s_q.rdy && i_pwrite && !s_q.err;

  for (genvar n = 0; n < ECR_NCH; n++) begin : g_route
    logic [31:0] cf;
    ecr_dir_t    dm;
    assign cf         = s_q.cfg[n];
    assign dm         = ecr_dir_t'(cf[ECR_F_DIR +: 2]);
    assign act_w[n]   = cf[ECR_F_EDGE] ? ecr_pick(fall_w, cf[ECR_F_SRC +: 3])
                                       : ecr_pick(rise_w, cf[ECR_F_SRC +: 3]); // [R02] [R11]
    assign rtrg_w[n]  = cf[ECR_F_RLDEN] && ecr_pick(rise_w, cf[ECR_F_RSEL +: 3]); // [R05] [R11]
    assign pause_w[n] = cf[ECR_F_PSEN]
                        && (ecr_pick(lvl_w, cf[ECR_F_PSEL +: 3]) == cf[ECR_F_PSLVL]); // [R06]
    assign up_w[n]    = (dm == ECR_EXT) ? ecr_pick(lvl_w, cf[ECR_F_DSEL +: 3]) // [R04]
                                        : (dm != ECR_DOWN);                    // [R03]
    assign arm_w[n]   = (s_q.ph[n] != ECR_IDLE);
    assign wrc_w[n]   = wr_acc && ((a_blk == 4'(n + 1))
                                   || (a_blk == ECR_BLK_GLB && a_wrd == ECR_W_ARM));
  end

  always_comb begin
    logic [31:0] nv;
    logic [3:0]  k;
    logic        hit;
    nv  = '0;
    k   = '0;
    hit = 1'b0;
    s_d = s_q;
    s_d.prev = lvl_w;
    s_d.di   = pass_mode ? pass_w : '0;      // [R08]

    for (int n = 0; n < ECR_NCH; n++) begin
      // counters freeze while the inputs are handed straight to software
      if (!pass_mode && s_q.ph[n] != ECR_IDLE) begin // [R09]
        if (rtrg_w[n]) begin
          s_d.cnt[n] = s_q.rld[n];           // [R05] [R16]
        end else if (act_w[n] && !pause_w[n]) begin // [R06]
          case (s_q.ph[n])
            ECR_WAIT: s_d.ph[n] = ECR_RUN;   // [R07]
            ECR_RUN: begin
              s_d.cnt[n] = up_w[n] ? s_q.cnt[n] + CW'(1)
                                   : s_q.cnt[n] - CW'(1); // [R03]
            end
            default: s_d.ph[n] = ECR_IDLE;
          endcase
        end
      end
    end

    s_d.rdy = 1'b0;
    s_d.err = 1'b0;
    if (i_psel && !i_penable) begin
      s_d.rdy   = 1'b1;
      s_d.rdata = '0;
      if (i_paddr[1:0] == 2'h0) begin
        if (a_blk == ECR_BLK_GLB) begin
          hit = 1'b1;
          case (a_wrd)
            ECR_W_CTRL: s_d.rdata = s_q.ctrl;
            ECR_W_ARM:  s_d.rdata = 32'(arm_w);
            ECR_W_DI:   s_d.rdata = 32'(s_q.di); // [R08]
            default:    hit = 1'b0;
          endcase
        end else if (a_blk <= 4'(ECR_NCH)) begin
          hit = 1'b1;
          k   = a_blk - 4'h1;
          case (a_wrd)
            ECR_W_CFG:  s_d.rdata = s_q.cfg[k];
            ECR_W_INIT: s_d.rdata = 32'(s_q.init[k]);
            ECR_W_RLD:  s_d.rdata = 32'(s_q.rld[k]);
            // sampling is read-only, the count keeps running
            default:    s_d.rdata = pass_mode ? '0 : 32'(s_q.cnt[k]); // [R15] [R09]
          endcase
        end
      end
      s_d.err = !hit;
    end

    // a write landing on the same edge wins over any hardware update
    if (wr_acc) begin
      if (a_blk == ECR_BLK_GLB) begin
        case (a_wrd)
          ECR_W_CTRL: s_d.ctrl = ecr_merge(s_q.ctrl, i_pwdata, i_pstrb);
          ECR_W_ARM: begin
            nv = ecr_merge(32'(arm_w), i_pwdata, i_pstrb);
            for (int n = 0; n < ECR_NCH; n++) begin
              if (!nv[n]) begin
                s_d.ph[n] = ECR_IDLE;
              end else if (s_q.ph[n] == ECR_IDLE) begin
                s_d.ph[n]  = ECR_WAIT;       // [R07]
                s_d.cnt[n] = s_q.init[n];    // [R01]
              end
            end
          end
          default: s_d.ctrl = s_q.ctrl;
        endcase
      end else begin
        k = a_blk - 4'h1;
        case (a_wrd)
          ECR_W_CFG: s_d.cfg[k] = ecr_merge(s_q.cfg[k], i_pwdata, i_pstrb); // [R11]
          ECR_W_INIT: begin
            s_d.init[k] = CW'(ecr_merge(32'(s_q.init[k]), i_pwdata, i_pstrb));
            if (s_q.ph[k] == ECR_IDLE) begin
              s_d.cnt[k] = s_d.init[k];      // [R01]
            end
          end
          ECR_W_RLD: s_d.rld[k] = CW'(ecr_merge(32'(s_q.rld[k]), i_pwdata, i_pstrb));
          default:   s_d.rld[k] = s_q.rld[k];
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q      <= '0;
      s_q.ctrl <= ECR_CTRL_RST;
      for (int n = 0; n < ECR_NCH; n++) begin
        s_q.cfg[n] <= ecr_cfg_rst(n);        // [R12] [R13] [R14]
        s_q.ph[n]  <= ECR_IDLE;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata  = s_q.rdata;
  assign o_pready  = s_q.rdy;
  assign o_pslverr = s_q.err;
  assign o_di      = s_q.di;

  apb_answer_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("apb access phase not answered");

  di_follow_a: assert property (pass_mode |=> o_di == $past(pass_w)) // [R08]
    else $error("passthrough level not shown");

  cnt_hidden_a: assert property ( // [R09]
    i_psel && !i_penable && pass_mode && a_blk != ECR_BLK_GLB && a_wrd == ECR_W_CNT
    |=> o_prdata == 32'h0000_0000)
    else $error("count visible in passthrough mode");

  di_zero_a: assert property (!pass_mode |=> o_di == '0) // [R09]
    else $error("levels shown outside passthrough mode");

  err_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("bus error without ready");

  // refused reads answer with zero data so no stale word leaks out
  bad_block_a: assert property (
    i_psel && !i_penable && a_blk > 4'(ECR_NCH) |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped block not refused");

  ready_once_a: assert property (o_pready && i_psel && i_penable |=> !o_pready)
    else $error("ready held past the access phase");

  ctrl_keep_a: assert property (
    !(wr_acc && a_blk == ECR_BLK_GLB && a_wrd == ECR_W_CTRL) |=> $stable(s_q.ctrl))
    else $error("control word changed without a write");

  for (genvar n = 0; n < ECR_NCH; n++) begin : g_chk
    logic quiet;
    assign quiet = !rtrg_w[n] && !wrc_w[n] && !pass_mode;
    logic arm_wr;
    // a set bit with its byte strobe off leaves the arm state as it was
    assign arm_wr = wr_acc && a_blk == ECR_BLK_GLB && a_wrd == ECR_W_ARM && i_pstrb[0];

    sequence wait_edge_s;
      s_q.ph[n] == ECR_WAIT && act_w[n] && !pause_w[n] && quiet;
    endsequence
    sequence run_start_s;
      s_q.ph[n] == ECR_RUN && $stable(s_q.cnt[n]);
    endsequence
    sequence arm_req_s;
      arm_wr && i_pwdata[n] && s_q.ph[n] == ECR_IDLE;
    endsequence
    sequence armed_s;
      s_q.ph[n] == ECR_WAIT && s_q.cnt[n] == $past(s_q.init[n]);
    endsequence

    edge_pulse_a: assert property (rise_w[n] |=> !rise_w[n]) // [R17]
      else $error("edge lasted more than one cycle");

    cnt_cause_a: assert property ( // [R02]
      !act_w[n] && !rtrg_w[n] && !wrc_w[n] |=> $stable(s_q.cnt[n]))
      else $error("count moved without a cause");

    up_step_a: assert property ( // [R03]
      s_q.ph[n] == ECR_RUN && act_w[n] && !pause_w[n] && quiet && up_w[n]
      |=> s_q.cnt[n] == $past(s_q.cnt[n]) + CW'(1))
      else $error("count did not step up");

    down_step_a: assert property ( // [R04]
      s_q.ph[n] == ECR_RUN && act_w[n] && !pause_w[n] && quiet && !up_w[n]
      |=> s_q.cnt[n] == $past(s_q.cnt[n]) - CW'(1))
      else $error("count did not step down");

    reload_win_a: assert property ( // [R16]
      rtrg_w[n] && arm_w[n] && !pass_mode && !wrc_w[n]
      |=> s_q.cnt[n] == $past(s_q.rld[n]))
      else $error("reload value not loaded");

    pause_hold_a: assert property ( // [R06]
      pause_w[n] && !rtrg_w[n] && !wrc_w[n] |=> $stable(s_q.cnt[n]))
      else $error("count moved while paused");

    arm_start_a: assert property (wait_edge_s |=> run_start_s) // [R07]
      else $error("first edge after arm mishandled");

    idle_hold_a: assert property ( // [R01]
      s_q.ph[n] == ECR_IDLE && !wrc_w[n] |=> $stable(s_q.cnt[n]))
      else $error("unarmed counter changed");

    arm_load_a: assert property (arm_req_s |=> armed_s) // [R01]
      else $error("arming did not load the starting count");

    disarm_idle_a: assert property (arm_wr && !i_pwdata[n] |=> s_q.ph[n] == ECR_IDLE) // [R07]
      else $error("counter still armed after disarm");

    // the first edge only opens counting, so the count must not move before it
    wait_hold_a: assert property ( // [R07]
      s_q.ph[n] == ECR_WAIT && !rtrg_w[n] && !wrc_w[n] |=> $stable(s_q.cnt[n]))
      else $error("count moved before the first edge");

    pause_start_a: assert property ( // [R06]
      s_q.ph[n] == ECR_WAIT && pause_w[n] && !wrc_w[n] |=> s_q.ph[n] == ECR_WAIT)
      else $error("paused counter left its wait phase");

    // frozen, not cleared, so leaving passthrough resumes where counting stopped
    pass_freeze_a: assert property ( // [R09]
      pass_mode && !wrc_w[n] |=> $stable(s_q.cnt[n]) && $stable(s_q.ph[n]))
      else $error("counter moved in passthrough mode");

    // the count word is a snapshot, never a clear
    cnt_read_a: assert property ( // [R15]
      i_psel && !i_penable && !pass_mode && i_paddr[1:0] == 2'h0
      && a_blk == 4'(n + 1) && a_wrd == ECR_W_CNT
      |=> o_prdata == 32'($past(s_q.cnt[n])))
      else $error("count read did not return the present count");

    cfg_keep_a: assert property ( // [R11]
      !wrc_w[n] |=> $stable(s_q.cfg[n]) && $stable(s_q.init[n]) && $stable(s_q.rld[n]))
      else $error("counter settings changed without a write");

    arm_read_a: assert property ( // [R07]
      i_psel && !i_penable && i_paddr[1:0] == 2'h0 && a_blk == ECR_BLK_GLB
      && a_wrd == ECR_W_ARM |=> o_prdata[n] == $past(arm_w[n]))
      else $error("arm state read back wrong");

    fall_pulse_a: assert property (fall_w[n] |=> !fall_w[n]) // [R17]
      else $error("falling edge lasted more than one cycle");

    ext_down_a: assert property ( // [R04]
      s_q.ph[n] == ECR_RUN && act_w[n] && !pause_w[n] && quiet
      && s_q.cfg[n][ECR_F_DIR +: 2] == 2'(ECR_EXT)
      && !ecr_pick(lvl_w, s_q.cfg[n][ECR_F_DSEL +: 3])
      |=> s_q.cnt[n] == $past(s_q.cnt[n]) - CW'(1))
      else $error("low direction input did not count down");
  end
endmodule : ecr_edge_counter

//--- include/ecr_pkg.sv
package ecr_pkg;
  localparam int          ECR_NCH      = 6;
  localparam int          ECR_SW       = 3;
  localparam int          ECR_AW       = 8;
  localparam int          ECR_CW       = 32;
  localparam int          ECR_FILT_CYC = 4;
  // block 0 holds global registers, counter n sits in block n+1
  localparam logic [3:0]  ECR_BLK_GLB  = 4'h0;
  localparam logic [1:0]  ECR_W_CTRL   = 2'h0;
  localparam logic [1:0]  ECR_W_ARM    = 2'h1;
  localparam logic [1:0]  ECR_W_DI     = 2'h2;
  localparam logic [1:0]  ECR_W_CFG    = 2'h0;
  localparam logic [1:0]  ECR_W_INIT   = 2'h1;
  localparam logic [1:0]  ECR_W_RLD    = 2'h2;
  localparam logic [1:0]  ECR_W_CNT    = 2'h3;
  localparam int          ECR_F_PASS   = 0;
  localparam int          ECR_F_FEN    = 8;
  localparam int          ECR_F_INV    = 16;
  localparam int          ECR_F_EDGE   = 0;
  localparam int          ECR_F_DIR    = 1;
  localparam int          ECR_F_RLDEN  = 3;
  localparam int          ECR_F_PSEN   = 4;
  localparam int          ECR_F_PSLVL  = 5;
  localparam int          ECR_F_SRC    = 8;
  localparam int          ECR_F_RSEL   = 12;
  localparam int          ECR_F_DSEL   = 16;
  localparam int          ECR_F_PSEL   = 20;
  localparam logic [31:0] ECR_CTRL_RST = 32'h0000_3F00;
  localparam logic [31:0] ECR_CFG_BASE = 32'h0000_0020;
  typedef enum logic [1:0] {ECR_UP = 2'h0, ECR_DOWN = 2'h1, ECR_EXT = 2'h2} ecr_dir_t;
  typedef enum logic [2:0] {ECR_IDLE = 3'h1, ECR_WAIT = 3'h2, ECR_RUN = 3'h4} ecr_ph_t;
  // entry n belongs to counter n
  localparam logic [5:0][2:0] ECR_DEF_RSEL = {3'h2, 3'h1, 3'h0, 3'h5, 3'h4, 3'h3};
  localparam logic [5:0][2:0] ECR_DEF_DSEL = {3'h0, 3'h3, 3'h1, 3'h4, 3'h2, 3'h5};
  localparam logic [5:0][2:0] ECR_DEF_PSEL = {3'h3, 3'h0, 3'h2, 3'h1, 3'h5, 3'h4};

  function automatic logic [31:0] ecr_cfg_rst(input int n);
    logic [31:0] c;
    c = ECR_CFG_BASE;
    c[ECR_F_SRC +: 3]  = 3'(n);              // [R12]
    c[ECR_F_RSEL +: 3] = ECR_DEF_RSEL[n];    // [R13]
    c[ECR_F_DSEL +: 3] = ECR_DEF_DSEL[n];    // [R14]
    c[ECR_F_PSEL +: 3] = ECR_DEF_PSEL[n];    // [R14]
    return c;
  endfunction : ecr_cfg_rst

  // selectors 6 and 7 name no channel and read as low
  function automatic logic ecr_pick(input logic [5:0] v, input logic [2:0] s);
    return (s < 3'h6) ? v[s] : 1'b0;
  endfunction : ecr_pick

  function automatic logic [31:0] ecr_merge(input logic [31:0] o, input logic [31:0] w,
                                            input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return r;
  endfunction : ecr_merge
endpackage : ecr_pkg

//--- logic/ecr_chan_cond.sv
module ecr_chan_cond #(
  parameter int FILT_CYC = ecr_pkg::ECR_FILT_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_raw,
  input  wire logic i_filt_en,
  input  wire logic i_inv,
  output logic      o_lvl,
  output logic      o_pass
);
  import ecr_pkg::*;
  localparam int FW = $clog2(FILT_CYC + 1);
  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          flt;
    logic [FW-1:0] cnt;
  } ecr_cs_t;
  ecr_cs_t s_q, s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = i_raw;                          // [R17]
    s_d.s2 = s_q.s1;                         // [R17]
    // a new level must persist FILT_CYC samples before it is believed
    if (s_q.s2 == s_q.flt) begin
      s_d.cnt = '0;
    end else if (s_q.cnt == FW'(FILT_CYC - 1)) begin
      s_d.flt = s_q.s2;
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + FW'(1);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_lvl  = i_filt_en ? s_q.flt : s_q.s2;
  assign o_pass = s_q.s2 ^ i_inv;            // [R10]
endmodule : ecr_chan_cond

//--- bench/ecr_chan_src.sv
module ecr_chan_src (
  input  wire logic       i_ref_clk,
  output logic      [5:0] o_chan
);
  timeunit 1ns;
  timeprecision 1ps;
  // each level outlasts the input synchroniser and the glitch filter, so no edge is lost
  localparam int HOLD = 6;

  initial o_chan = 6'h00;

  task automatic set_lvl(input logic [5:0] v);
    @(posedge i_ref_clk);
    o_chan <= v;
    repeat (HOLD) @(posedge i_ref_clk);
  endtask : set_lvl

  task automatic toggle(input int ch);
    @(posedge i_ref_clk);
    o_chan[ch] <= ~o_chan[ch];
    repeat (HOLD) @(posedge i_ref_clk);
  endtask : toggle
endmodule : ecr_chan_src

//--- bench/test_edge_counter_with_routing.sv
module test_edge_counter_with_routing;
  timeunit 1ns;
  timeprecision 1ps;
  import ecr_pkg::*;
  localparam int RS[6] = '{3, 4, 5, 0, 1, 2};
  localparam int DS[6] = '{5, 2, 4, 1, 3, 0};
  localparam int PS[6] = '{4, 5, 1, 2, 0, 3};
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err, fall, up;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, seed, r, ini, cfg;
  logic [5:0]  chan, di, lv, inv;
  int          err_count, checked, cyc, s, t, c;

  ecr_chan_src i_src (.i_ref_clk(clk), .o_chan(chan));
  ecr_edge_counter #(.CW(32), .FILT_CYC(2)) i_dut (
    .i_ref_clk(clk), .i_rst(rst), .i_chan(chan), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_di(di));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  function automatic logic [7:0] ad(input int n, input logic [1:0] w);
    return 8'(16 * (n + 1) + 4 * int'(w));
  endfunction : ad

  function automatic logic [31:0] cfg_def(input int n);
    return 32'h0000_0020 | (32'(n) << ECR_F_SRC) | (32'(RS[n]) << ECR_F_RSEL)
           | (32'(DS[n]) << ECR_F_DSEL) | (32'(PS[n]) << ECR_F_PSEL);
  endfunction : cfg_def

  // first active edge after arming only starts the counter
  function automatic logic [31:0] exp_cnt(input logic [31:0] i0, input bit u, input bit b,
                                          input bit f, input int n);
    int e;
    e = (b ^ f) ? n / 2 : (n + 1) / 2;
    if (e > 0) e--;
    return u ? i0 + 32'(e) : i0 - 32'(e);
  endfunction : exp_cnt

  task automatic finish_test();
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no local limit: a missing answer is caught by the cycle ceiling
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask : reg_wr

  task automatic cnt_test(input int n, input logic [31:0] cf, input logic [31:0] i0,
                          input logic [31:0] rl, input logic [5:0] l, input int tg,
                          input logic [31:0] ex);
    logic [31:0] x;
    logic        e;
    i_src.set_lvl(l);
    reg_wr(ad(n, ECR_W_CFG), cf);
    reg_wr(ad(n, ECR_W_INIT), i0);
    reg_wr(ad(n, ECR_W_RLD), rl);
    reg_wr(8'h04, 32'h1 << n);
    apb(1'b0, ad(n, ECR_W_CNT), 32'h0, x, e);
    chk("count_armed", i0, x);
    repeat (tg) i_src.toggle(int'(cf[ECR_F_SRC +: 3]));
    repeat (12) @(posedge clk);
    apb(1'b0, ad(n, ECR_W_CNT), 32'h0, x, e);
    chk("count", ex, x);
    apb(1'b0, ad(n, ECR_W_CNT), 32'h0, x, e);
    chk("count_reread", ex, x);
    reg_wr(8'h04, 32'h0);
  endtask : cnt_test

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    rst = 1'b1;
    seed = 32'h03EE;
    {err_count, checked, cyc} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, r, err);
    chk("ctrl_reset", ECR_CTRL_RST, r);
    chk("di_off", 32'h0, 32'(di));
    for (c = 0; c < 6; c++) begin
      apb(1'b0, ad(c, ECR_W_CFG), 32'h0, r, err);
      chk("cfg_reset", cfg_def(c), r);
    end
    apb(1'b0, 8'h0C, 32'h0, r, err);
    chk("pslverr_word3", 32'h1, 32'(err));
    apb(1'b0, 8'h70, 32'h0, r, err);
    chk("pslverr_block7", 32'h1, 32'(err));
    for (int i = 0; i < 12; i++) begin
      c = i % 6;
      fall = 1'(rnd());
      s = int'(rnd() % 6);
      t = 1 + int'(rnd() % 6);
      lv = 6'(rnd());
      ini = rnd();
      if (i % 3 == 2 && s == DS[c]) s = c;
      cfg = cfg_def(c);
      cfg[ECR_F_SRC +: 3] = 3'(s);
      cfg[ECR_F_EDGE] = fall;
      cfg[ECR_F_DIR +: 2] = 2'(i % 3);
      up = (i % 3 == 0) || (i % 3 == 2 && lv[DS[c]]);
      cnt_test(c, cfg, ini, 32'h0, lv, t, exp_cnt(ini, up, lv[s], fall, t));
    end
    cfg = cfg_def(3);
    cfg[ECR_F_SRC +: 3] = 3'h0;
    cfg[ECR_F_RLDEN] = 1'b1;
    r = rnd();
    cnt_test(3, cfg, rnd(), r, 6'h00, 5, r);
    cfg = cfg_def(4);
    cfg[ECR_F_PSEN] = 1'b1;
    r = rnd();
    cnt_test(4, cfg, r, 32'h0, 6'h01, 5, r);
    cnt_test(4, cfg, r, 32'h0, 6'h00, 5, r + 32'h2);
    lv = 6'(rnd());
    inv = 6'(rnd());
    reg_wr(8'h00, ECR_CTRL_RST | 32'h1 | (32'(inv) << ECR_F_INV));
    i_src.set_lvl(lv);
    apb(1'b0, 8'h08, 32'h0, r, err);
    chk("di_reg", 32'(lv ^ inv), r);
    chk("di_port", 32'(lv ^ inv), 32'(di));
    apb(1'b0, ad(0, ECR_W_CNT), 32'h0, r, err);
    chk("count_pass", 32'h0, r);
    reg_wr(8'h00, ECR_CTRL_RST);
    repeat (4) @(posedge clk);
    chk("di_after", 32'h0, 32'(di));
    finish_test();
  end
endmodule : test_edge_counter_with_routing
